// ---- src/evir_pkg.sv ----
// Package of addresses, field layouts, reset values and event numbering for event routing.
package evir_pkg;

    // ****************************************
    // Register addresses and bus widths
    // ****************************************
    localparam int ADDR_W = 32;
    localparam int DATA_W = 32;
    localparam logic [31:0] SEL_HIGH_ADDR = 32'h019c0000;
    localparam logic [31:0] SEL_LOW_ADDR = 32'h019c0004;
    localparam logic [31:0] CAP_LOW_ADDR = 32'h019c0008;
    localparam logic [31:0] CAP_HIGH_ADDR = 32'h019c000c;

    // ****************************************
    // Selector field layout and reset values
    // ****************************************
    localparam int SEL_W = 5;
    localparam int FIELDS_PER_REG = 6;
    localparam int FLD0_LSB = 0;
    localparam int FLD1_LSB = 5;
    localparam int FLD2_LSB = 10;
    localparam int FLD3_LSB = 16;
    localparam int FLD4_LSB = 21;
    localparam int FLD5_LSB = 26;
    localparam logic [31:0] SEL_FIELD_MASK = 32'h7fff7fff;
    localparam logic [31:0] SEL_LOW_RST = {1'b0, 5'h09, 5'h08, 5'h07, 1'b0, 5'h06, 5'h05,
        5'h04};
    localparam logic [31:0] SEL_HIGH_RST = {1'b0, 5'h02, 5'h01, 5'h00, 1'b0, 5'h0b, 5'h0a,
        5'h03};

    // ****************************************
    // Interrupt lines and source numbering
    // ****************************************
    localparam int NUM_LINES = 16;
    localparam int FIRST_MASKABLE = 4;
    localparam int NUM_SRC = 32;
    localparam int SRC_HOST = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_TIMER1 = 2;
    localparam int SRC_WIDE_REFRESH = 3;
    localparam int SRC_PIN4 = 4;
    localparam int SRC_DMA_DONE = 8;
    localparam int SRC_EMU_DTDMA = 9;
    localparam int SRC_EMU_RTDX_RX = 10;
    localparam int SRC_EMU_RTDX_TX = 11;
    localparam int SRC_SP0_TX = 12;
    localparam int SRC_SP1_TX = 14;
    localparam int SRC_PIN0 = 16;
    localparam int SRC_SP2_TX = 17;
    localparam int SRC_TIMER2 = 19;
    localparam int SRC_NARROW_REFRESH = 20;
    localparam int SRC_CELL = 23;
    localparam int SRC_CONV_DEC = 30;
    localparam int SRC_ITER_DEC = 31;

    // ****************************************
    // DMA channel numbering
    // ****************************************
    localparam int NUM_CH = 64;
    localparam int CH_HOST = 0;
    localparam int CH_TIMER0 = 1;
    localparam int CH_TIMER1 = 2;
    localparam int CH_WIDE_REFRESH = 3;
    localparam int CH_PIN4 = 4;
    localparam int CH_PIN0 = 8;
    localparam int CH_SP_FIRST = 12;
    localparam int CH_SP2_TX = 17;
    localparam int CH_SP2_RX = 18;
    localparam int CH_TIMER2 = 19;
    localparam int CH_NARROW_REFRESH = 20;
    localparam int CH_RESERVED = 21;
    localparam int CH_CONV_RX = 28;
    localparam int CH_CONV_TX = 29;
    localparam int CH_ITER_RX = 30;
    localparam int CH_ITER_TX = 31;
    localparam int CH_CELL_RX = 32;
    localparam int CH_CELL_TX = 40;
    localparam int CH_PIN8 = 48;

endpackage : evir_pkg

// ---- src/evir_line_sel.sv ----
// One maskable interrupt line: a 5-bit selector picks one of the event sources.
`timescale 1ns/10ps
module evir_line_sel
    import evir_pkg::*;
#(
    parameter int SRC_N = NUM_SRC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_sync_b,
    // Selection
    input wire logic [SEL_W-1:0] sel,
    input wire logic [SRC_N-1:0] src,
    // Line to the core
    output logic line_out
);

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            line_out <= 1'b0;
        end else begin
            line_out <= src[sel];
        end
    end

endmodule : evir_line_sel

// ---- src/evir_top.sv ----
// Event router: fixed DMA channel events and selectable CPU interrupt lines.
`timescale 1ns/10ps
module evir_top
    import evir_pkg::*;
#(
    parameter bit HAS_CELL_PORT = 1'b1,
    parameter bit HAS_DECODERS = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [DATA_W-1:0] wb_dat_i,
    output logic [DATA_W-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Peripheral events
    input wire logic host_port_event,
    input wire logic timer_zero_event,
    input wire logic timer_one_event,
    input wire logic timer_two_event,
    input wire logic wide_port_refresh_event,
    input wire logic narrow_port_refresh_event,
    input wire logic [15:0] pin_event,
    input wire logic [2:0] serial_port_tx_event,
    input wire logic [2:0] serial_port_rx_event,
    input wire logic conv_decoder_rx_event,
    input wire logic conv_decoder_tx_event,
    input wire logic iter_decoder_rx_event,
    input wire logic iter_decoder_tx_event,
    input wire logic cell_rx_event,
    input wire logic cell_tx_event,
    // Interrupt-only sources
    input wire logic cpu_reset_event,
    input wire logic nmi_event,
    input wire logic dma_done_int,
    input wire logic emu_dtdma_int,
    input wire logic emu_rtdx_rx_int,
    input wire logic emu_rtdx_tx_int,
    input wire logic cell_int,
    input wire logic conv_decoder_int,
    input wire logic iter_decoder_int,
    // Completion events from the DMA controller
    input wire logic [NUM_CH-1:0] transfer_done_event,
    input wire logic [NUM_CH-1:0] alt_transfer_done_event,
    // Outputs
    output logic [NUM_CH-1:0] dma_sync_event,
    output logic [NUM_LINES-1:0] cpu_int
);

    // ****************************************
    // Reset release
    // ****************************************
    logic [1:0] rsync_reg;
    logic rst_sync_b;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rsync_reg <= 2'b00;
        end else begin
            rsync_reg <= {rsync_reg[0], 1'b1};
        end
    end
    assign rst_sync_b = rsync_reg[1];

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] lane_mask(input logic [3:0] sel);
        lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction : lane_mask

    function automatic int field_lsb(input int slot);
        case (slot)
            0: field_lsb = FLD0_LSB;
            1: field_lsb = FLD1_LSB;
            2: field_lsb = FLD2_LSB;
            3: field_lsb = FLD3_LSB;
            4: field_lsb = FLD4_LSB;
            default: field_lsb = FLD5_LSB;
        endcase
    endfunction : field_lsb

    // ****************************************
    // Register decode
    // ****************************************
    logic ack_reg;
    logic [31:0] dat_reg;
    logic [31:0] sel_high_reg;
    logic [31:0] sel_low_reg;
    logic [NUM_CH-1:0] cap_reg;
    logic [NUM_CH-1:0] cap_next;
    wire bus_go = wb_cyc_i && wb_stb_i && !ack_reg;
    wire wr_go = bus_go && wb_we_i;
    wire [31:0] wr_mask = lane_mask(wb_sel_i);
    wire hit_sel_high = (wb_adr_i == SEL_HIGH_ADDR);
    wire hit_sel_low = (wb_adr_i == SEL_LOW_ADDR);
    wire hit_cap_low = (wb_adr_i == CAP_LOW_ADDR);
    wire hit_cap_high = (wb_adr_i == CAP_HIGH_ADDR);
    logic [31:0] rd_mux;

    always_comb begin
        if (hit_sel_high) begin
            rd_mux = sel_high_reg;
        end else if (hit_sel_low) begin
            rd_mux = sel_low_reg;
        end else if (hit_cap_low) begin
            rd_mux = cap_reg[31:0];
        end else if (hit_cap_high) begin
            rd_mux = cap_reg[63:32];
        end else begin
            rd_mux = 32'h00000000;
        end
    end

    wire [31:0] sel_high_wr = (sel_high_reg & ~wr_mask) | (wb_dat_i & wr_mask & SEL_FIELD_MASK);
    wire [31:0] sel_low_wr = (sel_low_reg & ~wr_mask) | (wb_dat_i & wr_mask & SEL_FIELD_MASK);
    wire [31:0] clr_low = (wr_go && hit_cap_low) ? (wb_dat_i & wr_mask) : 32'h00000000;
    wire [31:0] clr_high = (wr_go && hit_cap_high) ? (wb_dat_i & wr_mask) : 32'h00000000;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            ack_reg <= 1'b0;
            dat_reg <= 32'h00000000;
        end else begin
            ack_reg <= bus_go;
            if (bus_go) begin
                dat_reg <= rd_mux;
            end
        end
    end
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            sel_high_reg <= SEL_HIGH_RST;
            sel_low_reg <= SEL_LOW_RST;
        end else if (wr_go && hit_sel_high) begin
            sel_high_reg <= sel_high_wr;
        end else if (wr_go && hit_sel_low) begin
            sel_low_reg <= sel_low_wr;
        end
    end

    // ****************************************
    // DMA channel events
    // ****************************************
    // Each channel has at most one hard-wired peripheral source; there is no remap table on purpose.
    logic [NUM_CH-1:0] periph_event;

    always_comb begin
        periph_event = '0;
        periph_event[CH_HOST] = host_port_event;
        periph_event[CH_TIMER0] = timer_zero_event;
        periph_event[CH_TIMER1] = timer_one_event;
        periph_event[CH_WIDE_REFRESH] = wide_port_refresh_event;
        periph_event[CH_PIN4 +: 4] = pin_event[7:4];
        periph_event[CH_PIN0 +: 4] = pin_event[3:0];
        periph_event[CH_SP_FIRST] = serial_port_tx_event[0];
        periph_event[CH_SP_FIRST + 1] = serial_port_rx_event[0];
        periph_event[CH_SP_FIRST + 2] = serial_port_tx_event[1];
        periph_event[CH_SP_FIRST + 3] = serial_port_rx_event[1];
        periph_event[CH_SP2_TX] = serial_port_tx_event[2];
        periph_event[CH_SP2_RX] = serial_port_rx_event[2];
        periph_event[CH_TIMER2] = timer_two_event;
        periph_event[CH_NARROW_REFRESH] = narrow_port_refresh_event;
        periph_event[CH_CONV_RX] = HAS_DECODERS && conv_decoder_rx_event;
        periph_event[CH_CONV_TX] = HAS_DECODERS && conv_decoder_tx_event;
        periph_event[CH_ITER_RX] = HAS_DECODERS && iter_decoder_rx_event;
        periph_event[CH_ITER_TX] = HAS_DECODERS && iter_decoder_tx_event;
        periph_event[CH_CELL_RX] = HAS_CELL_PORT && cell_rx_event;
        periph_event[CH_CELL_TX] = HAS_CELL_PORT && cell_tx_event;
        periph_event[CH_PIN8 +: 8] = pin_event[15:8];
    end

    wire [NUM_CH-1:0] chan_event = periph_event | transfer_done_event
        | alt_transfer_done_event;
    // A new event wins over a clear written in the same cycle.
    assign cap_next = (cap_reg & ~{clr_high, clr_low}) | chan_event;

    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            dma_sync_event <= '0;
            cap_reg <= '0;
        end else begin
            dma_sync_event <= chan_event;
            cap_reg <= cap_next;
        end
    end

    // ****************************************
    // CPU interrupt lines
    // ****************************************
    logic [NUM_SRC-1:0] int_src;

    always_comb begin
        int_src = '0;
        int_src[SRC_HOST] = host_port_event;
        int_src[SRC_TIMER0] = timer_zero_event;
        int_src[SRC_TIMER1] = timer_one_event;
        int_src[SRC_WIDE_REFRESH] = wide_port_refresh_event;
        int_src[SRC_PIN4 +: 4] = pin_event[7:4];
        int_src[SRC_DMA_DONE] = dma_done_int;
        int_src[SRC_EMU_DTDMA] = emu_dtdma_int;
        int_src[SRC_EMU_RTDX_RX] = emu_rtdx_rx_int;
        int_src[SRC_EMU_RTDX_TX] = emu_rtdx_tx_int;
        int_src[SRC_SP0_TX] = serial_port_tx_event[0];
        int_src[SRC_SP0_TX + 1] = serial_port_rx_event[0];
        int_src[SRC_SP1_TX] = serial_port_tx_event[1];
        int_src[SRC_SP1_TX + 1] = serial_port_rx_event[1];
        int_src[SRC_PIN0] = pin_event[0];
        int_src[SRC_SP2_TX] = serial_port_tx_event[2];
        int_src[SRC_SP2_TX + 1] = serial_port_rx_event[2];
        int_src[SRC_TIMER2] = timer_two_event;
        int_src[SRC_NARROW_REFRESH] = narrow_port_refresh_event;
        int_src[SRC_CELL] = HAS_CELL_PORT && cell_int;
        int_src[SRC_CONV_DEC] = HAS_DECODERS && conv_decoder_int;
        int_src[SRC_ITER_DEC] = HAS_DECODERS && iter_decoder_int;
    end

    // Lines 2 and 3 have no source and stay low.
    always_ff @(posedge clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cpu_int[FIRST_MASKABLE-1:0] <= '0;
        end else begin
            cpu_int[FIRST_MASKABLE-1:0] <= {2'b00, nmi_event, cpu_reset_event};
        end
    end

    genvar gl;
    generate
        for (gl = FIRST_MASKABLE; gl < NUM_LINES; gl++) begin : g_line
            localparam int SLOT = (gl - FIRST_MASKABLE) % FIELDS_PER_REG;
            wire [31:0] src_reg = (gl < FIRST_MASKABLE + FIELDS_PER_REG) ? sel_low_reg
                : sel_high_reg;
            evir_line_sel #(
                .SRC_N(NUM_SRC)
            ) u_sel (
                .clk(clk),
                .rst_sync_b(rst_sync_b),
                .sel(src_reg[field_lsb(SLOT) +: SEL_W]),
                .src(int_src),
                .line_out(cpu_int[gl])
            );
        end
    endgenerate

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_b);

    wire line4_pick = int_src[sel_low_reg[4:0]];
    wire line15_pick = int_src[sel_high_reg[30:26]];

    sequence s_write_high;
        wr_go && hit_sel_high && (wb_sel_i == 4'hf);
    endsequence
    sequence s_high_updated;
        ##1 (sel_high_reg == $past(wb_dat_i & SEL_FIELD_MASK)) && wb_ack_o;
    endsequence
    sequence s_clear_cap0;
        wr_go && hit_cap_low && wb_dat_i[0] && wb_sel_i[0] && !chan_event[0];
    endsequence

    a_ch0_host: assert property (host_port_event |=> dma_sync_event[CH_HOST] && cap_reg[0])
        else $error("channel 0 missed host event");
    a_ch3_wide: assert property (wide_port_refresh_event |=> dma_sync_event[3])
        else $error("channel 3 missed refresh");
    a_ch20_narrow: assert property (narrow_port_refresh_event |=> dma_sync_event[20])
        else $error("channel 20 missed refresh");
    a_pin_channels: assert property (##1 dma_sync_event[7:4]
        == ($past(pin_event[7:4]) | $past(transfer_done_event[7:4])
        | $past(alt_transfer_done_event[7:4]))) else $error("pin channels wrong");
    a_ch21_quiet: assert property (!transfer_done_event[21] && !alt_transfer_done_event[21]
        |=> !dma_sync_event[21]) else $error("reserved channel fired");
    a_decoder_chans: assert property (conv_decoder_tx_event && iter_decoder_rx_event
        |=> dma_sync_event[29] == HAS_DECODERS && dma_sync_event[30] == HAS_DECODERS)
        else $error("decoder channels wrong");
    a_cell_chans: assert property (cell_tx_event && cell_rx_event
        |=> dma_sync_event[40] == HAS_CELL_PORT && dma_sync_event[32] == HAS_CELL_PORT)
        else $error("cell channels wrong");
    a_done_trigger: assert property (alt_transfer_done_event[50] |=> dma_sync_event[50])
        else $error("completion did not trigger");
    a_unassigned_quiet: assert property (!transfer_done_event[60]
        && !alt_transfer_done_event[60] |=> !dma_sync_event[60])
        else $error("unassigned channel fired");
    a_reset_line: assert property (cpu_reset_event |=> cpu_int[0])
        else $error("line 0 missed reset event");
    a_fixed_lines: assert property (cpu_int[3:2] == 2'b00)
        else $error("reserved lines active");
    a_line_route: assert property (##1 cpu_int[4] == $past(line4_pick)
        && cpu_int[15] == $past(line15_pick)) else $error("line routing wrong");
    a_sel_write: assert property (s_write_high |-> s_high_updated)
        else $error("high selector not written");
    a_cap_sticky: assert property (cap_reg[5] && !(wr_go && hit_cap_low) |=> cap_reg[5])
        else $error("capture bit lost");
    a_cap_clear: assert property (s_clear_cap0 |=> !cap_reg[0])
        else $error("capture clear ignored");

endmodule : evir_top

// ---- verif/evir_event_model.sv ----
// Behavioural model of the peripheral event sources that face the router.
`timescale 1ns/10ps
module evir_event_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Requested event levels and the levels driven to the router
    input wire logic [42:0] ev_req,
    output logic [42:0] ev
);
    // Sources change only just after an edge and hold their level, like real peripherals.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ev <= '0;
        end else begin
            ev <= ev_req;
        end
    end
endmodule : evir_event_model

// ---- verif/evir_top_tb.sv ----
// Self-checking testbench of the event router, full and reduced variants side by side.
`timescale 1ns/10ps
module evir_top_tb;
    import evir_pkg::*;
    // ****************************************
    // Signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = '0, dat = '0;
    logic [3:0] sel = '0;
    logic [42:0] ev_req = '0, ev;
    logic [63:0] td = '0, atd = '0;
    logic [31:0] rd [2];
    logic ack [2];
    logic [63:0] dse [2];
    logic [15:0] ci [2];
    logic [31:0] lo_s, hi_s;
    int mismatches = 0;
    int checked = 0;

    always #4 clk = ~clk;

    evir_event_model evir_event_model_i (.clk(clk), .rst_b(rst_b), .ev_req(ev_req), .ev(ev));
    // The second copy lacks the cell port and both decoders.
    for (genvar v = 0; v < 2; v++) begin : g_var
        evir_top #(.HAS_CELL_PORT(v == 0), .HAS_DECODERS(v == 0)) evir_top_i (
            .clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
            .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rd[v]), .wb_ack_o(ack[v]),
            .host_port_event(ev[0]), .timer_zero_event(ev[1]), .timer_one_event(ev[2]),
            .timer_two_event(ev[3]), .wide_port_refresh_event(ev[4]),
            .narrow_port_refresh_event(ev[5]), .pin_event(ev[21:6]),
            .serial_port_tx_event(ev[24:22]), .serial_port_rx_event(ev[27:25]),
            .conv_decoder_rx_event(ev[28]), .conv_decoder_tx_event(ev[29]),
            .iter_decoder_rx_event(ev[30]), .iter_decoder_tx_event(ev[31]),
            .cell_rx_event(ev[32]), .cell_tx_event(ev[33]), .cpu_reset_event(ev[34]),
            .nmi_event(ev[35]), .dma_done_int(ev[36]), .emu_dtdma_int(ev[37]),
            .emu_rtdx_rx_int(ev[38]), .emu_rtdx_tx_int(ev[39]), .cell_int(ev[40]),
            .conv_decoder_int(ev[41]), .iter_decoder_int(ev[42]),
            .transfer_done_event(td), .alt_transfer_done_event(atd),
            .dma_sync_event(dse[v]), .cpu_int(ci[v]));
    end

    // ****************************************
    // Expected routing
    // ****************************************
    function automatic logic [31:0] pack(input logic [4:0] a, b, c, d, e, f);
        return {1'b0, f, e, d, 1'b0, c, b, a};
    endfunction : pack

    function automatic logic [63:0] exp_ch(input logic [42:0] e, input bit full);
        logic [63:0] c;
        c = '0;
        c[2:0] = e[2:0];
        c[19] = e[3];
        c[3] = e[4];
        c[20] = e[5];
        c[7:4] = e[13:10];
        c[11:8] = e[9:6];
        c[55:48] = e[21:14];
        c[12] = e[22];
        c[13] = e[25];
        c[14] = e[23];
        c[15] = e[26];
        c[17] = e[24];
        c[18] = e[27];
        c[31:28] = e[31:28] & {4{full}};
        c[32] = e[32] & full;
        c[40] = e[33] & full;
        return c;
    endfunction : exp_ch

    function automatic logic [15:0] exp_int(input logic [42:0] e, input bit full);
        logic [31:0] s;
        logic [15:0] l;
        int b;
        s = '0;
        s[2:0] = e[2:0];
        s[3] = e[4];
        s[7:4] = e[13:10];
        s[11:8] = e[39:36];
        s[12] = e[22];
        s[13] = e[25];
        s[14] = e[23];
        s[15] = e[26];
        s[16] = e[6];
        s[17] = e[24];
        s[18] = e[27];
        s[19] = e[3];
        s[20] = e[5];
        s[23] = e[40] & full;
        s[31:30] = e[42:41] & {2{full}};
        l = {14'h0000, e[35:34]};
        for (int i = 0; i < 6; i++) begin
            b = i < 3 ? i * 5 : i * 5 + 1;
            l[4 + i] = s[lo_s[b+:5]];
            l[10 + i] = s[hi_s[b+:5]];
        end
        return l;
    endfunction : exp_int

    // ****************************************
    // Compare, bus and closing tasks
    // ****************************************
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_reg

    task automatic chk_evt(input logic [79:0] got, input logic [79:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_evt

    task automatic wb(input logic w, input logic [31:0] a, d, input logic [3:0] s,
            output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        do begin
            @(posedge clk);
            n++;
        end while (ack[0] !== 1'b1 && n < 50);
        if (ack[0] !== 1'b1) mismatches++;
        q = rd[0];
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
        logic [31:0] q;
        wb(1'b1, a, d, s, q);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'b0, a, 32'h00000000, 4'hf, q);
        chk_reg(q, exp);
    endtask : rdchk

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : tally_and_finish

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset_vals();
        lo_s = pack(5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09);
        hi_s = pack(5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02);
        rdchk(SEL_LOW_ADDR, lo_s);
        rdchk(SEL_HIGH_ADDR, hi_s);
    endtask : t_reset_vals

    task automatic t_sweep();
        for (int k = 0; k < 43; k++) begin
            @(posedge clk);
            ev_req <= 43'h1 << k;
            repeat (3) @(posedge clk);
            #1;
            for (int v = 0; v < 2; v++) begin
                chk_evt({dse[v], ci[v]}, {exp_ch(ev_req, v == 0), exp_int(ev_req, v == 0)});
            end
        end
        @(posedge clk);
        ev_req <= '0;
    endtask : t_sweep

    task automatic t_codes();
        for (int c = 0; c < 32; c++) begin
            lo_s = pack(c, c, c, c, c, c);
            hi_s = lo_s;
            wr(SEL_LOW_ADDR, lo_s);
            wr(SEL_HIGH_ADDR, hi_s);
            t_sweep();
        end
    endtask : t_codes

    task automatic t_bus_edges();
        wr(SEL_LOW_ADDR, 32'hffffffff);
        rdchk(SEL_LOW_ADDR, 32'h7fff7fff);
        wr(SEL_LOW_ADDR, 32'h00000000, 4'h1);
        rdchk(SEL_LOW_ADDR, 32'h7fff7f00);
        wr(32'h019c0010, 32'hffffffff);
        rdchk(32'h019c0010, 32'h00000000);
    endtask : t_bus_edges

    task automatic t_capture();
        @(posedge clk);
        ev_req <= 43'h2;
        repeat (3) @(posedge clk);
        wr(CAP_LOW_ADDR, 32'hffffffff);
        wr(CAP_HIGH_ADDR, 32'hffffffff);
        rdchk(CAP_LOW_ADDR, 32'h00000002);
        rdchk(CAP_HIGH_ADDR, 32'h00000000);
        @(posedge clk);
        ev_req <= '0;
        repeat (3) @(posedge clk);
        wr(CAP_LOW_ADDR, 32'hffffffff);
        rdchk(CAP_LOW_ADDR, 32'h00000000);
    endtask : t_capture

    task automatic t_done();
        @(posedge clk);
        td <= 64'h1 << 21;
        atd <= 64'h1 << 63;
        repeat (3) @(posedge clk);
        #1;
        for (int v = 0; v < 2; v++) begin
            chk_evt({dse[v], ci[v]}, {64'h8000000000200000, 16'h0000});
        end
        @(posedge clk);
        td <= '0;
        atd <= '0;
    endtask : t_done

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset_vals();
        t_sweep();
        t_codes();
        t_bus_edges();
        t_capture();
        t_done();
        tally_and_finish();
    end

    initial begin
        repeat (30000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule : evir_top_tb
